// ===== design/rsi_pkg.sv
package rsi_pkg;

  // Clock rate and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int STOP_RESP_MS = 1;
  // Longest response rounds down
  localparam int STOP_RESP_CYC = STOP_RESP_MS * (CLK_HZ / 1000);
  // Debounce window, well inside the stop response time
  localparam int DEB_US = 200;
  localparam int DEB_CYC = DEB_US * (CLK_HZ / 1_000_000);
  localparam int DEB_W = 16;

  // Values after reset
  localparam logic RST_SWITCH = 1'b0;
  localparam logic RST_STOP = 1'b1;

  // Input vector positions
  localparam int IN_STOP = 0;
  localparam int IN_DOOR = 1;
  localparam int IN_ENDEV = 2;
  localparam int IN_TB_EN = 3;
  localparam int IN_TB_SW = 4;
  localparam int IN_KEY_A = 5;
  localparam int IN_KEY_B = 6;
  localparam int IN_N = 7;

  typedef enum logic [1:0] {
    RSI_SERVO_OFF = 2'b00,
    RSI_SERVO_ON = 2'b01,
    RSI_STOPPED = 2'b10
  } rsi_state_t;

endpackage : rsi_pkg

// ===== design/rsi_debounce.sv
`timescale 1ns/1ps
`default_nettype none

module rsi_debounce #(
  parameter int DEB_CYC = rsi_pkg::DEB_CYC,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic raw,
  output logic clean
);

  initial begin
    if (DEB_CYC < 1 || DEB_CYC >= (1 << rsi_pkg::DEB_W)) begin
      $error("rsi_debounce: DEB_CYC out of range");
    end
  end

  logic sync1_r;
  logic sync2_r;
  logic [rsi_pkg::DEB_W-1:0] cnt_r;
  logic clean_r;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync1_r <= RST_VAL;
      sync2_r <= RST_VAL;
    end else begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // A change must hold steady for the whole window, so one glitch is lost
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_r <= '0;
      clean_r <= RST_VAL;
    end else if (sync2_r == clean_r) begin
      cnt_r <= '0;
    end else if (cnt_r == rsi_pkg::DEB_W'(DEB_CYC - 1)) begin
      cnt_r <= '0;
      clean_r <= sync2_r;
    end else begin
      cnt_r <= cnt_r + rsi_pkg::DEB_W'(1);
    end
  end

  assign clean = clean_r;

endmodule : rsi_debounce

`default_nettype wire

// ===== design/rsi_interlock.sv
// Operation
// - A special stop input stops motion, and each of its edges is seen within 1 ms.
// - An open fence door drops servo power, unless teaching with the enabling device held, without raising an error.
// - A closed door contact means door closed and an open contact means door open.
// - While teaching, servo power and pendant jogging stay possible with the door open.
// - With the door open, servo-on needs pendant enable switch and enabling device both held.
// - With the door open, releasing the enabling device drops servo power at once.
// - With the door open, servo-on and brake release are refused while the device is released.
// - With the door closed, the pendant alone may turn servo power on.
// - Manual jog is allowed with pendant enabled, its switch on, enabling device closed.
// - Manual jog with the enabling device open is allowed only with the door closed.
// - Brake release needs manual mode, pendant enabled, switch on, enabling device closed.
// - Automatic run needs automatic mode, pendant disabled and door closed throughout.
// - Mode comes from two key lines that must agree, or a key-line fault is raised.
`timescale 1ns/1ps
`default_nettype none

module rsi_interlock #(
  parameter int DEB_CYC = rsi_pkg::DEB_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic stop_in,
  input wire logic door_contact,
  input wire logic enable_dev,
  input wire logic tb_enabled,
  input wire logic tb_enable_sw,
  input wire logic key_line_a,
  input wire logic key_line_b,
  input wire logic servo_on_req,
  input wire logic brake_rel_req,
  input wire logic auto_run_req,
  output logic servo_power,
  output logic jog_allow,
  output logic brake_release,
  output logic auto_run,
  output logic motion_stop,
  output logic manual_mode,
  output logic key_fault,
  output logic door_open
);

  initial begin
    // Debounce plus two sync stages and one register stage must fit the stop response
    if (DEB_CYC + 3 > rsi_pkg::STOP_RESP_CYC) begin
      $error("rsi_interlock: debounce too long for stop response");
    end
  end

  logic [rsi_pkg::IN_N-1:0] raw;
  logic [rsi_pkg::IN_N-1:0] cln;

  assign raw = {key_line_b, key_line_a, tb_enable_sw, tb_enabled, enable_dev,
                door_contact, stop_in};

  ////////////////////////////////////////////////////////////////////////
  // Input conditioning
  genvar gi;
  generate
    for (gi = 0; gi < rsi_pkg::IN_N; gi++) begin : g_in
      rsi_debounce #(
        .DEB_CYC(DEB_CYC),
        .RST_VAL(gi == rsi_pkg::IN_STOP ? rsi_pkg::RST_STOP : rsi_pkg::RST_SWITCH)
      ) u_deb (
        .mclk(mclk),
        .srst(srst),
        .raw(raw[gi]),
        .clean(cln[gi])
      );
    end
  endgenerate

  logic stop_c;
  logic door_closed_c;
  logic endev_c;
  logic tb_c;
  logic tbsw_c;
  logic keys_agree;
  logic manual_c;
  assign stop_c = cln[rsi_pkg::IN_STOP];
  assign door_closed_c = cln[rsi_pkg::IN_DOOR];
  assign endev_c = cln[rsi_pkg::IN_ENDEV];
  assign tb_c = cln[rsi_pkg::IN_TB_EN];
  assign tbsw_c = cln[rsi_pkg::IN_TB_SW];
  assign keys_agree = cln[rsi_pkg::IN_KEY_A] == cln[rsi_pkg::IN_KEY_B];
  // Both lines open selects manual, both closed selects automatic
  assign manual_c = ~cln[rsi_pkg::IN_KEY_A];

  ////////////////////////////////////////////////////////////////////////
  // Mode decode; on disagreement the last agreed mode is kept
  logic manual_r;
  logic key_fault_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      manual_r <= 1'b1;
      key_fault_r <= 1'b0;
    end else begin
      key_fault_r <= ~keys_agree;
      if (keys_agree) begin
        manual_r <= manual_c;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Permissions
  logic pendant_ok;
  logic teach_ok;
  logic jog_ok;
  logic brake_ok;
  logic auto_ok;
  logic servo_keep;
  assign pendant_ok = manual_r & ~key_fault_r & tb_c & tbsw_c;
  // Door open: pendant and enabling device; door closed: pendant alone
  assign jog_ok = pendant_ok & (endev_c | door_closed_c);
  assign teach_ok = jog_ok;
  assign brake_ok = pendant_ok & endev_c;
  assign auto_ok = ~manual_r & ~key_fault_r & ~tb_c & door_closed_c;
  assign servo_keep = ~stop_c & (teach_ok | auto_ok);

  ////////////////////////////////////////////////////////////////////////
  // Servo power sequencing
  rsi_pkg::rsi_state_t state_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= rsi_pkg::RSI_STOPPED;
    end else begin
      case (state_r)
        rsi_pkg::RSI_STOPPED: begin
          if (~stop_c) begin
            state_r <= rsi_pkg::RSI_SERVO_OFF;
          end
        end
        rsi_pkg::RSI_SERVO_OFF: begin
          if (stop_c) begin
            state_r <= rsi_pkg::RSI_STOPPED;
          end else if (servo_on_req & servo_keep) begin
            state_r <= rsi_pkg::RSI_SERVO_ON;
          end
        end
        rsi_pkg::RSI_SERVO_ON: begin
          if (stop_c) begin
            state_r <= rsi_pkg::RSI_STOPPED;
          end else if (~servo_keep) begin
            state_r <= rsi_pkg::RSI_SERVO_OFF;
          end
        end
        default: begin
          state_r <= rsi_pkg::RSI_STOPPED;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs; servo drop uses the live permission so it is not late
  logic jog_r;
  logic brake_r;
  logic auto_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      jog_r <= 1'b0;
      brake_r <= 1'b0;
      auto_r <= 1'b0;
    end else begin
      jog_r <= (state_r == rsi_pkg::RSI_SERVO_ON) & servo_keep & jog_ok;
      // Held off until the stopped state is left, so a stop always ends a release
      brake_r <= brake_rel_req & brake_ok & ~stop_c
                 & (state_r != rsi_pkg::RSI_STOPPED);
      auto_r <= auto_run_req & (state_r == rsi_pkg::RSI_SERVO_ON) & servo_keep & auto_ok;
    end
  end

  assign servo_power = (state_r == rsi_pkg::RSI_SERVO_ON) & servo_keep;
  assign jog_allow = jog_r;
  assign brake_release = brake_r;
  assign auto_run = auto_r;
  assign motion_stop = stop_c | (state_r == rsi_pkg::RSI_STOPPED);
  assign manual_mode = manual_r;
  // Door opening is not an error: only the key fault is reported
  assign key_fault = key_fault_r;
  assign door_open = ~door_closed_c;

endmodule : rsi_interlock

`default_nettype wire

// ===== verif/rsi_interlock_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module rsi_interlock_asserts #(
  parameter int DEB_CYC = 4
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic stop_in,
  input wire logic door_contact,
  input wire logic enable_dev,
  input wire logic key_line_a,
  input wire logic key_line_b,
  input wire logic servo_power,
  input wire logic jog_allow,
  input wire logic brake_release,
  input wire logic auto_run,
  input wire logic motion_stop,
  input wire logic manual_mode,
  input wire logic key_fault,
  input wire logic door_open
);
  // Sync plus debounce plus one register stage
  localparam int SMAX = DEB_CYC + 3;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////////////////////////////////
  a_stop_halts: assert property (motion_stop |-> !servo_power) else $error("servo on in stop");
  a_stop_timely: assert property ($rose(stop_in) |-> ##[1:SMAX] motion_stop)
    else $error("stop late");
  a_stop_clears: assert property ($fell(stop_in) |-> ##[1:SMAX] !motion_stop)
    else $error("stop stuck");
  a_door_seen: assert property ($fell(door_contact) ##1 !door_contact [*8] |-> door_open)
    else $error("door open missed");
  a_endev_drop: assert property ($fell(enable_dev) |-> ##[1:SMAX] (!servo_power || !door_open))
    else $error("servo kept");
  a_jog_manual: assert property (jog_allow |-> $past(manual_mode)) else $error("jog in auto");
  a_brake_manual: assert property (brake_release |-> $past(manual_mode && !motion_stop))
    else $error("brake not allowed");
  a_auto_door: assert property (auto_run |-> $past(!door_open && !manual_mode))
    else $error("auto not allowed");
  a_key_block: assert property (key_fault [*2] |-> !auto_run) else $error("auto in fault");
  a_key_seen: assert property ($rose(key_line_a ^ key_line_b) |-> ##[1:SMAX] key_fault)
    else $error("key fault missed");
  cover property ($rose(servo_power));
  cover property ($rose(brake_release));
  cover property ($rose(auto_run));
endmodule : rsi_interlock_asserts

bind rsi_interlock rsi_interlock_asserts #(.DEB_CYC(DEB_CYC)) i_chk (.mclk, .srst, .stop_in,
  .door_contact, .enable_dev, .key_line_a, .key_line_b, .servo_power, .jog_allow,
  .brake_release, .auto_run, .motion_stop, .manual_mode, .key_fault, .door_open);
`default_nettype wire

// ===== verif/rsi_switches.sv
`timescale 1ns/1ps
`default_nettype none

module rsi_switches (
  input wire logic [6:0] cmd,
  input wire logic glitch,
  output logic [6:0] pins
);
  // Contacts are levels; a high door pin is a closed contact
  // A bounce is a single-cycle flip of the door contact
  assign pins = cmd ^ {5'h00, glitch, 1'b0};
endmodule : rsi_switches
`default_nettype wire

// ===== verif/test_rsi_interlock.sv
`timescale 1ns/1ps
`default_nettype none

module test_rsi_interlock;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic sreq = 1'b0;
  logic breq = 1'b0;
  logic areq = 1'b0;
  logic glitch = 1'b0;
  logic [6:0] cmd = 7'h1A;
  logic [6:0] pins;
  logic [31:0] seed = 32'h914E;
  logic sp, jog, brk, aut, mstop, man, kf, dopen;
  int bad_count = 0;
  int checks_done = 0;
  always #10 mclk = ~mclk;
  rsi_switches i_sw (.cmd(cmd), .glitch(glitch), .pins(pins));
  rsi_interlock #(.DEB_CYC(4)) i_dut (.mclk(mclk), .srst(srst), .stop_in(pins[0]),
    .door_contact(pins[1]), .enable_dev(pins[2]), .tb_enabled(pins[3]),
    .tb_enable_sw(pins[4]), .key_line_a(pins[5]), .key_line_b(pins[6]),
    .servo_on_req(sreq), .brake_rel_req(breq), .auto_run_req(areq), .servo_power(sp),
    .jog_allow(jog), .brake_release(brk), .auto_run(aut), .motion_stop(mstop),
    .manual_mode(man), .key_fault(kf), .door_open(dopen));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  // Long enough for sync, debounce and the output register
  task automatic apply(input logic [6:0] v);
    @(negedge mclk);
    cmd = v;
    repeat (20) @(negedge mclk);
  endtask : apply
  task automatic servo();
    sreq = 1'b1;
    @(negedge mclk);
    sreq = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : servo
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    bad_count++;
    results();
  end
  initial begin
    repeat (6) @(negedge mclk);
    srst = 1'b0;
    chk(mstop, 1'b1);
    chk(man, 1'b1);
    apply(7'h1A);
    servo();
    chk(sp, 1'b1);
    chk(jog, 1'b1);
    apply(7'h18);
    chk(sp, 1'b0);
    chk(dopen, 1'b1);
    chk(kf | mstop, 1'b0);
    servo();
    chk(sp, 1'b0);
    apply(7'h1C);
    servo();
    chk(sp, 1'b1);
    chk(jog, 1'b1);
    breq = 1'b1;
    repeat (3) @(negedge mclk);
    chk(brk, 1'b1);
    apply(7'h18);
    chk(sp | brk, 1'b0);
    breq = 1'b0;
    apply(7'h1E);
    glitch = 1'b1;
    @(negedge mclk);
    glitch = 1'b0;
    repeat (12) @(negedge mclk);
    chk(dopen, 1'b0);
    servo();
    chk(sp, 1'b1);
    apply(7'h1F);
    chk(mstop, 1'b1);
    chk(sp, 1'b0);
    areq = 1'b1;
    apply(7'h62);
    servo();
    chk(aut, 1'b1);
    chk(man, 1'b0);
    apply(7'h60);
    chk(aut, 1'b0);
    areq = 1'b0;
    apply(7'h22);
    chk(kf, 1'b1);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      breq = seed[5];
      apply({2'b00, seed[4:1], 1'b0});
      chk(brk, seed[5] & seed[2] & seed[3] & seed[4]);
    end
    results();
  end
endmodule : test_rsi_interlock
`default_nettype wire
